// >>> hw/charge_flags_regs.svh
// Register offsets, field positions, reset values for the charge flag block.
`ifndef CHARGE_FLAGS_REGS_SVH
`define CHARGE_FLAGS_REGS_SVH

// ==========================================================================
// Byte offsets on the register bus
`define OFS_CONTROL          8'h00
`define OFS_FLAGS            8'h04
`define OFS_FIRST_SET        8'h08
`define OFS_FIRST_CLEAR      8'h0c
`define OFS_FINAL_SET        8'h10
`define OFS_FINAL_CLEAR      8'h14
`define OFS_REMAINING        8'h18
`define OFS_CHARGE_ACC       8'h1c
`define OFS_INT_STATUS       8'h20
`define OFS_INT_CLEAR        8'h24
`define OFS_INT_ENABLE       8'h28

// ==========================================================================
// Control fields
`define CTRL_EVAL_EN_BIT     0
`define CTRL_TWO_CELL_BIT    1
`define CTRL_CLR_SHORT_BIT   2
`define CTRL_CLR_TAB_BIT     3
`define CTRL_CLR_ACC_BIT     4

// ==========================================================================
// Flag word and interrupt layout (shared)
`define FLAG_FINAL_BIT       0
`define FLAG_EARLY_BIT       1
`define FLAG_SHORT_BIT       2
`define FLAG_TAB_BIT         3
`define FLAG_WIDTH           4

// ==========================================================================
// Reset values
`define RST_CONTROL          2'h1
`define RST_FIRST_SET        16'h0096
`define RST_FIRST_CLEAR      16'h00af
`define RST_FINAL_SET        16'h004b
`define RST_FINAL_CLEAR      16'h0064
`define RST_INT_ENABLE       4'h0
`define FINAL_DISABLED_LEVEL 16'hffff

`endif

// >>> hw/charge_flags_pkg.sv
// Types shared by the charge flag block.
package charge_flags_pkg;

  // ========================================================================
  // Data types
  typedef logic        [31:0] word_type;
  typedef logic signed [15:0] level_type;
  typedef logic        [15:0] capacity_type;
  typedef logic signed [15:0] sample_type;
  typedef logic        [3:0]  flag_vec_type;

endpackage

// >>> hw/charge_flags.sv
// Battery charge level and cell condition warning flags with Wishbone access.
`timescale 1ns/1ps
`include "charge_flags_regs.svh"

module charge_flags #(
  parameter int ACC_WIDTH = 32 // Width of the charge accumulator.
) (
  input  wire logic                         clk_sys,         // 125 MHz clock
  input  wire logic                         rst_n,           // Async reset
  input  wire logic                         wb_cyc_i,        // Bus cycle
  input  wire logic                         wb_stb_i,        // Bus strobe
  input  wire logic                         wb_we_i,         // Write enable
  input  wire logic [7:0]                   wb_adr_i,        // Byte address
  input  wire logic [3:0]                   wb_sel_i,        // Byte lanes
  input  wire charge_flags_pkg::word_type   wb_dat_i,        // Write data
  output charge_flags_pkg::word_type        wb_dat_o,        // Read data
  output logic                              wb_ack_o,        // Acknowledge
  input  wire logic                         capacity_valid,  // New capacity
  input  wire charge_flags_pkg::capacity_type remaining_capacity_mah, // mAh
  input  wire logic                         short_check_valid, // Check done
  input  wire logic                         short_detected,  // Short found
  input  wire logic                         soh_check_valid, // Health done
  input  wire logic                         tab_lost,        // Tab open
  input  wire logic                         sense_valid,     // New sample
  input  wire charge_flags_pkg::sample_type sense_charge,    // Signed charge
  output logic                              early_low_charge_flag, // Flag
  output logic                              final_low_charge_flag, // Flag
  output logic                              internal_short_flag,   // Flag
  output logic                              tab_disconnect_flag,   // Flag
  output logic                              irq              // Interrupt
);
  import charge_flags_pkg::*;

  // ========================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_n_q;
  default clocking sys_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n_q);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q   <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // ========================================================================
  // Register state
  logic                        eval_en_q;
  logic                        two_cell_q;
  level_type                   first_set_q;
  level_type                   first_clear_q;
  level_type                   final_set_q;
  level_type                   final_clear_q;
  capacity_type                capacity_q;
  logic signed [ACC_WIDTH-1:0] charge_acc_q;
  flag_vec_type                int_status_q;
  flag_vec_type                int_enable_q;
  logic                        early_q;
  logic                        final_q;
  logic                        short_q;
  logic                        tab_q;
  logic                        ack_q;
  word_type                    rdata_q;

  // ========================================================================
  // Bus decode
  logic req;
  logic wr;
  logic wr_ctrl;
  logic clr_short;
  logic clr_tab;
  logic clr_acc;

  assign req       = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr        = req && wb_we_i && wb_sel_i[0];
  assign wr_ctrl   = wr && (wb_adr_i == `OFS_CONTROL);
  assign clr_short = wr_ctrl && wb_dat_i[`CTRL_CLR_SHORT_BIT];
  assign clr_tab   = wr_ctrl && wb_dat_i[`CTRL_CLR_TAB_BIT];
  assign clr_acc   = wr_ctrl && wb_dat_i[`CTRL_CLR_ACC_BIT];

  // Thresholds take byte lanes 0 and 1 independently.
  function automatic level_type merge_level(input level_type old_v);
    return {wb_sel_i[1] ? wb_dat_i[15:8] : old_v[15:8],
            wb_sel_i[0] ? wb_dat_i[7:0] : old_v[7:0]};
  endfunction

  // ========================================================================
  // Configuration registers
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      {two_cell_q, eval_en_q} <= `RST_CONTROL;
      first_set_q   <= `RST_FIRST_SET;
      first_clear_q <= `RST_FIRST_CLEAR;
      final_set_q   <= `RST_FINAL_SET;
      final_clear_q <= `RST_FINAL_CLEAR;
      int_enable_q  <= `RST_INT_ENABLE;
    end else if (req && wb_we_i) begin
      case (wb_adr_i)
        `OFS_CONTROL: if (wb_sel_i[0]) begin
          eval_en_q  <= wb_dat_i[`CTRL_EVAL_EN_BIT];
          two_cell_q <= wb_dat_i[`CTRL_TWO_CELL_BIT];
        end
        `OFS_FIRST_SET:   first_set_q   <= merge_level(first_set_q);
        `OFS_FIRST_CLEAR: first_clear_q <= merge_level(first_clear_q);
        `OFS_FINAL_SET:   final_set_q   <= merge_level(final_set_q);
        `OFS_FINAL_CLEAR: final_clear_q <= merge_level(final_clear_q);
        `OFS_INT_ENABLE: if (wb_sel_i[0]) begin
          int_enable_q <= wb_dat_i[`FLAG_WIDTH-1:0];
        end
        default: begin end
      endcase
    end
  end

  // ========================================================================
  // Capacity comparisons
  // Capacity is unsigned and levels signed, so compare in 17 signed bits.
  logic signed [16:0] cap_s;
  logic               eval;
  logic               below_first;
  logic               above_first;
  logic               below_final;
  logic               above_final;
  logic               final_armed;
  logic               early_d;
  logic               final_d;

  assign cap_s       = $signed({1'b0, remaining_capacity_mah});
  assign eval        = capacity_valid && eval_en_q;
  assign below_first = cap_s < $signed({first_set_q[15], first_set_q});
  assign above_first = cap_s > $signed({first_clear_q[15], first_clear_q});
  assign below_final = cap_s < $signed({final_set_q[15], final_set_q});
  assign above_final = cap_s > $signed({final_clear_q[15], final_clear_q});
  assign final_armed = final_set_q != `FINAL_DISABLED_LEVEL;

  always_comb begin
    early_d = early_q;
    final_d = final_q;
    if (eval) begin
      if (below_first) begin
        early_d = 1'b1;
      end else if (above_first) begin
        early_d = 1'b0;
      end
      if (below_final && final_armed) begin
        final_d = 1'b1;
      end else if (above_final && final_q) begin
        final_d = 1'b0;
      end
    end
  end

  // Flags move only when a fresh capacity result is evaluated.
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      early_q    <= 1'b0;
      final_q    <= 1'b0;
      capacity_q <= 16'h0000;
    end else begin
      early_q <= early_d;
      final_q <= final_d;
      if (capacity_valid) begin
        capacity_q <= remaining_capacity_mah;
      end
    end
  end

  // ========================================================================
  // Cell condition flags
  // Sticky until software clears them; a detection wins a same-cycle clear.
  logic short_evt;
  logic tab_evt;

  assign short_evt = short_check_valid && short_detected;
  assign tab_evt   = soh_check_valid && tab_lost && two_cell_q;

  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      short_q <= 1'b0;
      tab_q   <= 1'b0;
    end else begin
      if (short_evt) begin
        short_q <= 1'b1;
      end else if (clr_short) begin
        short_q <= 1'b0;
      end
      if (tab_evt) begin
        tab_q <= 1'b1;
      end else if (clr_tab) begin
        tab_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Charge integration
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      charge_acc_q <= '0;
    end else if (sense_valid) begin
      charge_acc_q <= charge_acc_q + ACC_WIDTH'(sense_charge);
    end else if (clr_acc) begin
      charge_acc_q <= '0;
    end
  end

  // ========================================================================
  // Interrupts
  flag_vec_type events;
  flag_vec_type int_clear;

  assign events[`FLAG_FINAL_BIT] = final_d && !final_q;
  assign events[`FLAG_EARLY_BIT] = early_d && !early_q;
  assign events[`FLAG_SHORT_BIT] = short_evt;
  assign events[`FLAG_TAB_BIT]   = tab_evt;
  assign int_clear = (wr && (wb_adr_i == `OFS_INT_CLEAR))
                     ? wb_dat_i[`FLAG_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      int_status_q <= '0;
    end else begin
      int_status_q <= (int_status_q & ~int_clear) | events;
    end
  end

  assign irq = |(int_status_q & int_enable_q);

  // ========================================================================
  // Read path and acknowledge
  flag_vec_type flag_word;
  word_type     rmux;

  assign flag_word = {tab_q, short_q, early_q, final_q};

  always_comb begin
    rmux = '0;
    case (wb_adr_i)
      `OFS_CONTROL:     rmux = {30'h0, two_cell_q, eval_en_q};
      `OFS_FLAGS:       rmux = {28'h0, flag_word};
      `OFS_FIRST_SET:   rmux = {16'h0, first_set_q};
      `OFS_FIRST_CLEAR: rmux = {16'h0, first_clear_q};
      `OFS_FINAL_SET:   rmux = {16'h0, final_set_q};
      `OFS_FINAL_CLEAR: rmux = {16'h0, final_clear_q};
      `OFS_REMAINING:   rmux = {16'h0, capacity_q};
      `OFS_CHARGE_ACC:  rmux = 32'(charge_acc_q);
      `OFS_INT_STATUS:  rmux = {28'h0, int_status_q};
      `OFS_INT_ENABLE:  rmux = {28'h0, int_enable_q};
      default:          rmux = '0;
    endcase
  end

  // Every access, mapped or not, is answered one cycle later.
  always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        rdata_q <= rmux;
      end
    end
  end

  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = rdata_q;
  assign early_low_charge_flag = early_q;
  assign final_low_charge_flag = final_q;
  assign internal_short_flag   = short_q;
  assign tab_disconnect_flag   = tab_q;

  // ========================================================================
  // Assertions
  sequence s_flags_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q
      && wb_adr_i == `OFS_FLAGS ##1 wb_ack_o;
  endsequence

  property p_early_set;
    eval && below_first |=> early_low_charge_flag;
  endproperty
  a_early_set: assert property (p_early_set)
    else $error("early flag not set below first level");

  property p_early_hyst;
    eval && !below_first && !above_first
      |=> early_low_charge_flag == $past(early_low_charge_flag);
  endproperty
  a_early_hyst: assert property (p_early_hyst)
    else $error("early flag moved inside hysteresis band");

  property p_early_clear;
    eval && !below_first && above_first |=> !early_low_charge_flag;
  endproperty
  a_early_clear: assert property (p_early_clear)
    else $error("early flag not cleared above clear level");

  property p_final_set;
    eval && below_final && final_set_q != `FINAL_DISABLED_LEVEL
      |=> final_low_charge_flag;
  endproperty
  a_final_set: assert property (p_final_set)
    else $error("final flag not set below final level");

  property p_final_off;
    final_set_q == `FINAL_DISABLED_LEVEL && !final_low_charge_flag
      |=> !final_low_charge_flag;
  endproperty
  a_final_off: assert property (p_final_off)
    else $error("final flag set while disabled");

  property p_final_clear;
    eval && final_low_charge_flag && above_final && !below_final
      |=> !final_low_charge_flag;
  endproperty
  a_final_clear: assert property (p_final_clear)
    else $error("final flag not cleared above clear level");

  property p_short_set;
    short_evt |=> short_q ##1 (short_q || $past(clr_short));
  endproperty
  a_short_set: assert property (p_short_set)
    else $error("short flag not held after detection");

  property p_tab_set;
    soh_check_valid && tab_lost && two_cell_q
      |=> tab_disconnect_flag ##0 int_status_q[`FLAG_TAB_BIT];
  endproperty
  a_tab_set: assert property (p_tab_set)
    else $error("tab flag or status not set");

  property p_accumulate;
    sense_valid |=> charge_acc_q
      == $past(charge_acc_q) + ACC_WIDTH'($past(sense_charge));
  endproperty
  a_accumulate: assert property (p_accumulate)
    else $error("charge accumulator did not add sample");

  property p_flags_word;
    s_flags_read |-> wb_dat_o == {28'h0, $past(flag_word)};
  endproperty
  a_flags_word: assert property (p_flags_word)
    else $error("flags word does not match flags");

  property p_hold;
    !capacity_valid |=> $stable(early_q) && $stable(final_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("capacity flag changed without evaluation");

endmodule

// >>> tb/host_model.sv
// Host processor model that reads and writes the flag block over Wishbone.
`timescale 1ns/1ps

module host_model (
  input  wire logic        clk_sys, // Bus clock
  output logic             cyc,     // Cycle
  output logic             stb,     // Strobe
  output logic             we,      // Write enable
  output logic [7:0]       adr,     // Byte address
  output logic [3:0]       sel,     // Byte lanes
  output logic [31:0]      dat_w,   // Write data
  input  wire logic [31:0] dat_r,   // Read data
  input  wire logic        ack      // Acknowledge
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h00000000;
  end

  // ======================================================================
  // One classic cycle; only the bench watchdog ends a wait for ack.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Released data is inverted so a stale word is never mistaken.
    dat_w <= ~d;
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the charge warning flag block.
`timescale 1ns/1ps
`include "charge_flags_regs.svh"
`define CHK(g, e) cmp(32'(g), 32'(e))

module tb;
  import charge_flags_pkg::*;
  logic         clk_sys, rst_n, capacity_valid, short_check_valid;
  logic         short_detected, soh_check_valid, tab_lost, sense_valid;
  logic         cyc, stb, we, ack, irq, fe, fl, fs, ft;
  logic [7:0]   adr;
  logic [3:0]   sel;
  word_type     dw, dr;
  capacity_type cap_v;
  sample_type   smp;
  int           n_errors, num_checks;

  host_model i_host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_w(dw), .dat_r(dr), .ack(ack));
  charge_flags i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .capacity_valid(capacity_valid), .remaining_capacity_mah(cap_v),
    .short_check_valid(short_check_valid), .short_detected(short_detected),
    .soh_check_valid(soh_check_valid), .tab_lost(tab_lost),
    .sense_valid(sense_valid), .sense_charge(smp),
    .early_low_charge_flag(fe), .final_low_charge_flag(fl),
    .internal_short_flag(fs), .tab_disconnect_flag(ft), .irq(irq));

  // ======================================================================
  // Helpers
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e);
  endtask

  task automatic cap(input logic [15:0] v, input logic [3:0] e);
    @(posedge clk_sys);
    capacity_valid <= 1'b1;
    cap_v <= v;
    @(posedge clk_sys);
    capacity_valid <= 1'b0;
    #1;
    `CHK({ft, fs, fe, fl}, e);
  endtask

  task automatic cond(input logic tab, input logic hit);
    @(posedge clk_sys);
    if (tab) begin
      soh_check_valid <= 1'b1;
      tab_lost <= hit;
    end else begin
      short_check_valid <= 1'b1;
      short_detected <= hit;
    end
    @(posedge clk_sys);
    soh_check_valid <= 1'b0;
    short_check_valid <= 1'b0;
    #1;
  endtask

  task automatic sense(input logic [15:0] v);
    @(posedge clk_sys);
    sense_valid <= 1'b1;
    smp <= v;
    @(posedge clk_sys);
    sense_valid <= 1'b0;
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_reset();
    rd(`OFS_CONTROL, 32'h1);
    rd(`OFS_FIRST_SET, 32'h96);
    rd(`OFS_FIRST_CLEAR, 32'haf);
    rd(`OFS_FINAL_SET, 32'h4b);
    rd(`OFS_FINAL_CLEAR, 32'h64);
    rd(`OFS_INT_ENABLE, 32'h0);
    wr(`OFS_FLAGS, 32'hf);
    rd(`OFS_FLAGS, 32'h0);
    rd(8'h3c, 32'h0);
  endtask

  task automatic t_early();
    cap(16'd150, 4'h0);
    cap(16'd149, 4'h2);
    cap(16'd175, 4'h2);
    cap_v <= 16'd300;
    repeat (4) @(posedge clk_sys);
    `CHK(fe, 1'b1);
    cap(16'd176, 4'h0);
  endtask

  task automatic t_final();
    cap(16'd75, 4'h2);
    cap(16'd74, 4'h3);
    cap(16'd100, 4'h3);
    rd(`OFS_FLAGS, 32'h3);
    cap(16'd101, 4'h2);
    wr(`OFS_FINAL_SET, 32'hffff);
    cap(16'd0, 4'h2);
    wr(`OFS_FINAL_SET, 32'h4b);
    cap(16'd200, 4'h0);
    rd(`OFS_REMAINING, 32'd200);
    wr(`OFS_CONTROL, 32'h0);
    cap(16'd10, 4'h0);
    rd(`OFS_REMAINING, 32'd10);
  endtask

  task automatic t_cond();
    cond(1'b0, 1'b0);
    `CHK(fs, 1'b0);
    cond(1'b0, 1'b1);
    `CHK(fs, 1'b1);
    cond(1'b1, 1'b1);
    `CHK(ft, 1'b0);
    wr(`OFS_CONTROL, 32'h3);
    cond(1'b1, 1'b1);
    `CHK(ft, 1'b1);
    rd(`OFS_FLAGS, 32'hc);
    wr(`OFS_CONTROL, 32'hf);
    rd(`OFS_FLAGS, 32'h0);
    wr(`OFS_CONTROL, 32'h1);
  endtask

  task automatic t_irq();
    wr(`OFS_INT_CLEAR, 32'hf);
    rd(`OFS_INT_STATUS, 32'h0);
    wr(`OFS_INT_ENABLE, 32'h2);
    rd(`OFS_INT_ENABLE, 32'h2);
    cap(16'd100, 4'h2);
    `CHK(irq, 1'b1);
    wr(`OFS_INT_ENABLE, 32'h0);
    `CHK(irq, 1'b0);
    wr(`OFS_INT_ENABLE, 32'h2);
    `CHK(irq, 1'b1);
    wr(`OFS_INT_CLEAR, 32'h2);
    `CHK(irq, 1'b0);
    rd(`OFS_INT_STATUS, 32'h0);
  endtask

  task automatic t_acc();
    wr(`OFS_CONTROL, 32'h11);
    sense(16'd5);
    sense(16'hfffd);
    rd(`OFS_CHARGE_ACC, 32'h2);
    sense(16'hfff9);
    rd(`OFS_CHARGE_ACC, 32'hfffffffb);
  endtask

  // ======================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  initial begin
    {rst_n, capacity_valid, short_check_valid, short_detected} = 4'h0;
    {soh_check_valid, tab_lost, sense_valid} = 3'h0;
    cap_v = 16'd500;
    smp = 16'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_early();
    t_final();
    t_cond();
    t_irq();
    t_acc();
    close_out();
  end
endmodule
